/* rtl/sfsf_filter.sv */
`timescale 1ns/1ns
// How it works
// - fast mode output every (3 + avg - 1) sinc periods, each 1024 x word master clocks
// - both averaging bits zero: plain continuous sinc3, no fast settling
// - chop off in fast mode: each result settled within one output period
// - channel change restarts a conversion, no extra delay in fast mode
// - conversions continue through steps; a fresh restart each period limits smear to one
// - sinc decimation is 64 x word samples, notch at master clock / (1024 x word)
// - postfilter averages avg sinc results, notches at sinc notch / avg
// - 60 Hz notch enable adds half-period delayed sample, rate unchanged
// - chop alternates polarity, one settled conversion each, averages successive pairs
// - chop leaves rate unchanged in fast mode, first result after two periods
// - word 30, average 16 gives 8.9 Hz from the rate relation
// - word 5, average 16 gives 53.39 Hz from the rate relation
// - chop off in fast mode: one result per output period regardless of channel switching
// - averaging select 01, 10, 11 average by 2, 8, 16
// - 60 Hz notch enable is one configuration bit held with the word
module sfsf_filter (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // modulator bitstream pin
  input wire logic MOD_BIT,
  // configuration
  input wire sfsf_pkg::sfsf_cfg_s CFG,
  input wire logic CHANNEL_CHANGE,
  // modulator and input switch control
  output logic MOD_SAMPLE,
  output logic CHOP_POLARITY,
  // results and status
  output logic signed [sfsf_pkg::ACC_W-1:0] RESULT,
  output logic RESULT_VALID,
  output logic FAST_MODE
);
  localparam int AW = sfsf_pkg::ACC_W;

  logic [sfsf_pkg::MCLK_ACC_W-1:0] mclk_acc, next_mclk_acc;
  logic [sfsf_pkg::MOD_DIV_W-1:0] mod_cnt, next_mod_cnt;
  logic mod_tick, next_mod_tick;
  logic bit_meta, bit_sync;
  logic signed [AW-1:0] int1, int2, int3, next_int1, next_int2, next_int3;
  logic signed [AW-1:0] dly1, dly2, dly3, next_dly1, next_dly2, next_dly3;
  logic signed [AW-1:0] avg_sum, next_avg_sum;
  logic signed [AW-1:0] chop_prev, next_chop_prev;
  logic have_prev, next_have_prev;
  logic [sfsf_pkg::DEC_W-1:0] dec_cnt, next_dec_cnt;
  logic [4:0] sinc_cnt, next_sinc_cnt;
  logic change_pend, next_change_pend;
  sfsf_pkg::sfsf_cfg_s cfg, next_cfg;
  logic polarity, next_polarity;
  logic signed [AW-1:0] result, next_result;
  logic result_valid, next_result_valid;
  logic fast_mode, next_fast_mode;
  logic [sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_DELAY-1:0] rej_mem;
  logic [sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_PTR_W-1:0] rej_ptr, next_rej_ptr;
  logic rej_old;
  logic rej_full, next_rej_full;

  // decimation length and averaging from the latched configuration
  logic [sfsf_pkg::WORD_W-1:0] word_eff;
  logic [sfsf_pkg::DEC_W-1:0] dec_len;
  logic [4:0] avg_amt;
  logic [2:0] avg_shift;
  logic fast_sel;

  always_comb begin
    word_eff = (cfg.filter_word == '0) ? sfsf_pkg::WORD_W'(1) : cfg.filter_word;
    dec_len = {word_eff, sfsf_pkg::DEC_SHIFT'(0)};
    fast_sel = cfg.averaging_select_high | cfg.averaging_select_low;
    unique case ({cfg.averaging_select_high, cfg.averaging_select_low})
      2'b01: begin
        avg_amt = sfsf_pkg::AVG_2;
        avg_shift = 3'(sfsf_pkg::SHIFT_2);
      end
      2'b10: begin
        avg_amt = sfsf_pkg::AVG_8;
        avg_shift = 3'(sfsf_pkg::SHIFT_8);
      end
      2'b11: begin
        avg_amt = sfsf_pkg::AVG_16;
        avg_shift = 3'(sfsf_pkg::SHIFT_16);
      end
      2'b00: begin
        avg_amt = 5'h00;
        avg_shift = 3'h0;
      end
    endcase
  end

  // master clock as a fractional enable, modulator rate one sixteenth of it
  always_comb begin
    logic [sfsf_pkg::MCLK_ACC_W-1:0] sum;
    logic mclk_tick;
    sum = '0;
    mclk_tick = 1'b0;
    sum = mclk_acc + sfsf_pkg::MCLK_ACC_W'(sfsf_pkg::MCLK_HZ);
    next_mclk_acc = sum;
    if (sum >= sfsf_pkg::MCLK_ACC_W'(sfsf_pkg::CLK_HZ)) begin
      next_mclk_acc = sum - sfsf_pkg::MCLK_ACC_W'(sfsf_pkg::CLK_HZ);
      mclk_tick = 1'b1;
    end
    next_mod_cnt = mod_cnt;
    next_mod_tick = 1'b0;
    if (mclk_tick) begin
      next_mod_cnt = mod_cnt + sfsf_pkg::MOD_DIV_W'(1);
      next_mod_tick = (mod_cnt == sfsf_pkg::MOD_DIV_W'(sfsf_pkg::MOD_DIV - 1));
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mclk_acc <= '0;
      mod_cnt <= '0;
      mod_tick <= 1'b0;
      bit_meta <= 1'b0;
      bit_sync <= 1'b0;
    end else begin
      mclk_acc <= next_mclk_acc;
      mod_cnt <= next_mod_cnt;
      mod_tick <= next_mod_tick;
      bit_meta <= MOD_BIT;
      bit_sync <= bit_meta;
    end
  end

  // delay line for the 60 Hz notch; no reset, contents ignored until filled once
  assign rej_old = rej_mem[rej_ptr];
  always_ff @(posedge CLK_SYS) begin
    if (mod_tick) begin
      rej_mem[rej_ptr] <= bit_sync;
    end
  end

  // sinc3 integrate, decimate, comb; postfilter; chop
  always_comb begin
    logic signed [2:0] x;
    logic signed [AW-1:0] c1, c2, c3, conv, chopped;
    logic produce, restart;
    x = '0;
    c1 = '0;
    c2 = '0;
    c3 = '0;
    conv = '0;
    chopped = '0;
    produce = 1'b0;
    restart = 1'b0;
    next_int1 = int1;
    next_int2 = int2;
    next_int3 = int3;
    next_dly1 = dly1;
    next_dly2 = dly2;
    next_dly3 = dly3;
    next_avg_sum = avg_sum;
    next_chop_prev = chop_prev;
    next_have_prev = have_prev;
    next_dec_cnt = dec_cnt;
    next_sinc_cnt = sinc_cnt;
    next_change_pend = change_pend | CHANNEL_CHANGE;
    next_cfg = cfg;
    next_polarity = polarity;
    next_result = result;
    next_result_valid = 1'b0;
    next_fast_mode = fast_sel;
    next_rej_ptr = rej_ptr;
    next_rej_full = rej_full;
    if (mod_tick) begin
      next_rej_ptr = (rej_ptr == sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_PTR_W'(sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_DELAY - 1)) ?
                     '0 : rej_ptr + sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_PTR_W'(1);
      if (rej_ptr == sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_PTR_W'(sfsf_pkg::SIXTY_HZ_NOTCH_ENABLE_DELAY - 1)) begin
        next_rej_full = 1'b1;
      end
      x = bit_sync ? 3'sd1 : -3'sd1;
      if (cfg.sixty_hz_notch_enable) begin
        // unfilled line: repeat the new sample so the scale stays that of the notch
        x = x + ((rej_full ? rej_old : bit_sync) ? 3'sd1 : -3'sd1);
      end
      next_int1 = int1 + AW'(x);
      next_int2 = int2 + next_int1;
      next_int3 = int3 + next_int2;
      next_dec_cnt = dec_cnt + sfsf_pkg::DEC_W'(1);
      if (dec_cnt == dec_len - sfsf_pkg::DEC_W'(1)) begin
        next_dec_cnt = '0;
        c1 = next_int3 - dly1;
        c2 = c1 - dly2;
        c3 = c2 - dly3;
        next_dly1 = next_int3;
        next_dly2 = c1;
        next_dly3 = c2;
        if (sinc_cnt != 5'h1F) begin
          next_sinc_cnt = sinc_cnt + 5'h01;
        end
        if (fast_sel) begin
          if (next_sinc_cnt > sfsf_pkg::SINC_DISCARD) begin
            next_avg_sum = avg_sum + c3;
          end
          if (next_sinc_cnt == sfsf_pkg::SINC_DISCARD + avg_amt) begin
            conv = next_avg_sum >>> avg_shift;
            produce = 1'b1;
            restart = 1'b1;
          end
        end else if (next_sinc_cnt >= sfsf_pkg::SINC_SETTLED) begin
          conv = c3;
          produce = 1'b1;
          restart = cfg.chop_enable;
        end
      end
      if (change_pend) begin
        // channel switch: drop the partial conversion and the chop history
        restart = 1'b1;
        produce = 1'b0;
        next_have_prev = 1'b0;
        next_polarity = 1'b0;
        next_change_pend = CHANNEL_CHANGE;
      end
    end
    if (produce) begin
      if (cfg.chop_enable) begin
        chopped = polarity ? -conv : conv;
        next_polarity = ~polarity;
        next_chop_prev = chopped;
        next_have_prev = 1'b1;
        if (have_prev) begin
          next_result = (chopped + chop_prev) >>> 1;
          next_result_valid = 1'b1;
        end
      end else begin
        next_have_prev = 1'b0;
        next_result = conv;
        next_result_valid = 1'b1;
      end
    end
    if (restart) begin
      // configuration taken only between conversions so none is torn
      next_cfg = CFG;
      next_int1 = '0;
      next_int2 = '0;
      next_int3 = '0;
      next_dly1 = '0;
      next_dly2 = '0;
      next_dly3 = '0;
      next_avg_sum = '0;
      next_dec_cnt = '0;
      next_sinc_cnt = '0;
      if (!CFG.chop_enable) begin
        next_have_prev = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
      avg_sum <= '0;
      chop_prev <= '0;
      have_prev <= 1'b0;
      dec_cnt <= '0;
      sinc_cnt <= '0;
      change_pend <= 1'b1;
      cfg <= '0;
      polarity <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
      fast_mode <= 1'b0;
      rej_ptr <= '0;
      rej_full <= 1'b0;
    end else begin
      int1 <= next_int1;
      int2 <= next_int2;
      int3 <= next_int3;
      dly1 <= next_dly1;
      dly2 <= next_dly2;
      dly3 <= next_dly3;
      avg_sum <= next_avg_sum;
      chop_prev <= next_chop_prev;
      have_prev <= next_have_prev;
      dec_cnt <= next_dec_cnt;
      sinc_cnt <= next_sinc_cnt;
      change_pend <= next_change_pend;
      cfg <= next_cfg;
      polarity <= next_polarity;
      result <= next_result;
      result_valid <= next_result_valid;
      fast_mode <= next_fast_mode;
      rej_ptr <= next_rej_ptr;
      rej_full <= next_rej_full;
    end
  end

  // MOD_SAMPLE is the registered sample tick itself
  assign MOD_SAMPLE = mod_tick;
  assign CHOP_POLARITY = polarity;
  assign RESULT = result;
  assign RESULT_VALID = result_valid;
  assign FAST_MODE = fast_mode;
endmodule

/* rtl/sfsf_pkg.sv */
package sfsf_pkg;
  // clock figures
  localparam int CLK_HZ = 50_000_000;
  localparam int MCLK_HZ = 4_920_000;
  localparam int MCLK_ACC_W = 27;
  // master clock ticks per modulator sample
  localparam int MOD_DIV = 16;
  localparam int MOD_DIV_W = 4;
  // sinc notch sits at master clock / (1024 x word): 1024 / 16 samples per word unit
  localparam int NOTCH_DIV = 1024;
  localparam int DEC_SHIFT = 6;
  localparam int DEC_W = 16;
  localparam int WORD_W = 10;
  // third-order sinc: three sinc periods before a result is settled
  localparam int SINC_ORDER = 3;
  localparam logic [4:0] SINC_SETTLED = 5'h03;
  localparam logic [4:0] SINC_DISCARD = 5'h02;
  // postfilter averaging amounts and the matching shifts
  localparam logic [4:0] AVG_2 = 5'h02;
  localparam logic [4:0] AVG_8 = 5'h08;
  localparam logic [4:0] AVG_16 = 5'h10;
  localparam int SHIFT_2 = 1;
  localparam int SHIFT_8 = 3;
  localparam int SHIFT_16 = 4;
  // accumulator width: 3 x 16 bits growth, 3-bit input, 4 bits of averaging, sign
  localparam int ACC_W = 56;
  // added 60 Hz notch: half a 60 Hz period of modulator samples, rounded
  localparam int SIXTY_HZ_NOTCH_ENABLE_HZ = 60;
  localparam int SIXTY_HZ_NOTCH_ENABLE_DELAY = (MCLK_HZ + MOD_DIV * SIXTY_HZ_NOTCH_ENABLE_HZ) / (MOD_DIV * 2 * SIXTY_HZ_NOTCH_ENABLE_HZ);
  localparam int SIXTY_HZ_NOTCH_ENABLE_PTR_W = 12;

  typedef struct packed {
    logic [WORD_W-1:0] filter_word;
    logic averaging_select_high;
    logic averaging_select_low;
    logic sixty_hz_notch_enable;
    logic chop_enable;
  } sfsf_cfg_s;
endpackage

/* testbench/sfsf_filter_properties.sv */
`timescale 1ns/1ns
module sfsf_filter_properties (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // inputs
  input wire logic MOD_BIT,
  input wire sfsf_pkg::sfsf_cfg_s CFG,
  input wire logic CHANNEL_CHANGE,
  // outputs
  input wire logic MOD_SAMPLE,
  input wire logic CHOP_POLARITY,
  input wire logic signed [sfsf_pkg::ACC_W-1:0] RESULT,
  input wire logic RESULT_VALID,
  input wire logic FAST_MODE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  logic [7:0] gap;
  logic seen;
  logic [23:0] ticks;
  logic pend;
  logic [23:0] period;
  logic [23:0] mult;
  logic [9:0] word;
  logic [1:0] avg_bits;
  assign avg_bits = {CFG.averaging_select_high, CFG.averaging_select_low};
  assign word = (CFG.filter_word == 10'h000) ? 10'h001 : CFG.filter_word;
  always_comb begin
    case (avg_bits)
      2'b01: mult = 24'h000004;
      2'b10: mult = 24'h00000A;
      default: mult = 24'h000012;
    endcase
    period = mult * {8'h00, word, 6'h00};
  end
  // ticks since last result or since the restart that a pending change forces
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      gap <= 8'h00;
      seen <= 1'b0;
      ticks <= 24'h000000;
      pend <= 1'b1;
    end else begin
      gap <= MOD_SAMPLE ? 8'h01 : ((gap == 8'hFF) ? gap : gap + 8'h01);
      seen <= seen | MOD_SAMPLE;
      ticks <= (RESULT_VALID || (MOD_SAMPLE && pend)) ? 24'h000000 :
               ticks + {23'h000000, MOD_SAMPLE};
      pend <= CHANNEL_CHANGE | (pend & !MOD_SAMPLE);
    end
  end
  sequence s_strobe_gap;
    !RESULT_VALID [*8];
  endsequence
  sequence s_tick_gap;
    !MOD_SAMPLE [*8];
  endsequence
  pulse_valid_a: assert property (RESULT_VALID |=> s_strobe_gap)
    else $error("result strobe longer than one cycle");
  valid_tick_a: assert property (RESULT_VALID |-> $past(MOD_SAMPLE))
    else $error("result strobe not after a sample tick");
  tick_quiet_a: assert property (MOD_SAMPLE |=> s_tick_gap)
    else $error("sample ticks too close");
  tick_spacing_a: assert property (MOD_SAMPLE && seen |-> gap inside {[160:165]})
    else $error("sample tick spacing off master clock over 16");
  fast_rate_a: assert property (RESULT_VALID && FAST_MODE && !CFG.chop_enable |->
    ticks == period)
    else $error("fast mode output period wrong");
  // mode follows the configuration latched at a restart tick, two cycles on
  fast_follow_a: assert property ($changed(FAST_MODE) |->
    $past(MOD_SAMPLE, 2) && FAST_MODE == (|$past(avg_bits, 2)))
    else $error("fast mode flag disagrees with averaging bits");
  result_hold_a: assert property (!RESULT_VALID |-> $stable(RESULT))
    else $error("result changed without strobe");
  polarity_step_a: assert property ($changed(CHOP_POLARITY) |-> $past(MOD_SAMPLE))
    else $error("polarity changed off a sample tick");
endmodule

/* testbench/sfsf_mod_model.sv */
`timescale 1ns/1ns
module sfsf_mod_model (
  // analog stand-in
  input wire logic level,
  input wire logic polarity,
  // bitstream
  output logic mod_bit
);
  // swapped input pins invert the bit density
  assign mod_bit = level ^ polarity;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic CLK_SYS;
  logic RESET;
  logic MOD_BIT;
  sfsf_pkg::sfsf_cfg_s CFG;
  logic CHANNEL_CHANGE;
  logic MOD_SAMPLE;
  logic CHOP_POLARITY;
  logic signed [sfsf_pkg::ACC_W-1:0] RESULT;
  logic RESULT_VALID;
  logic FAST_MODE;
  logic level;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int d;
  int p_clk;
  sfsf_filter sfsf_filter_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .MOD_BIT(MOD_BIT), .CFG(CFG),
    .CHANNEL_CHANGE(CHANNEL_CHANGE), .MOD_SAMPLE(MOD_SAMPLE), .CHOP_POLARITY(CHOP_POLARITY),
    .RESULT(RESULT), .RESULT_VALID(RESULT_VALID), .FAST_MODE(FAST_MODE));
  sfsf_mod_model sfsf_mod_model_i (.level(level), .polarity(CHOP_POLARITY), .mod_bit(MOD_BIT));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) cyc <= cyc + 1;
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // counts cycles from now to the next result strobe, bounded
  task automatic wait_valid(input int limit, output int span);
    int start;
    start = cyc;
    do begin
      @(posedge CLK_SYS);
      #1;
    end while (RESULT_VALID !== 1'b1 && cyc - start < limit);
    span = cyc - start;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge CLK_SYS);
    mismatches++;
    conclude();
  end
  initial begin
    // word 1, average 2: (3 + 2 - 1) x 1024 master clocks per result
    p_clk = int'(real'(4 * 1024) * sfsf_pkg::CLK_HZ / sfsf_pkg::MCLK_HZ);
    RESET = 1'b1;
    CHANNEL_CHANGE = 1'b0;
    level = 1'b1;
    CFG = '{10'h001, 1'b0, 1'b0, 1'b0, 1'b0}; // 1.2 kHz kept: no fourth-order path
    repeat (2) @(posedge CLK_SYS);
    #1 RESET = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1 check("fast_mode_off", FAST_MODE, 64'h0);
    CFG.averaging_select_low = 1'b1;
    while (MOD_SAMPLE !== 1'b1) begin
      @(posedge CLK_SYS);
      #1;
    end
    wait_valid(50000, d);
    check("first_settle", (d >= p_clk - 4) && (d <= p_clk + 4), 64'h1);
    check("full_scale_pos", RESULT, 64'h0000_0000_0004_0000);
    // configuration only takes effect at the restart tick
    check("fast_mode_on", FAST_MODE, 64'h1);
    check("polarity_normal", CHOP_POLARITY, 64'h0);
    repeat (100) @(posedge CLK_SYS);
    // step aligned with the restart: only a settled result may follow
    #1 level = 1'b0;
    CHANNEL_CHANGE = 1'b1;
    @(posedge CLK_SYS);
    #1 CHANNEL_CHANGE = 1'b0;
    wait_valid(50000, d);
    check("switch_latency", (d >= p_clk - 4) && (d <= p_clk + 170), 64'h1);
    check("full_scale_neg", RESULT, 64'hFFFF_FFFF_FFFC_0000);
    conclude();
  end
endmodule
bind sfsf_filter sfsf_filter_properties sfsf_filter_properties_i (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .MOD_BIT(MOD_BIT), .CFG(CFG), .CHANNEL_CHANGE(CHANNEL_CHANGE),
  .MOD_SAMPLE(MOD_SAMPLE), .CHOP_POLARITY(CHOP_POLARITY), .RESULT(RESULT),
  .RESULT_VALID(RESULT_VALID), .FAST_MODE(FAST_MODE));
